// ### include/timer_pkg.sv
// Constants, encodings and carrier types shared by the general-purpose timer.
// Assumes a single system clock domain; this file holds no logic.
`default_nettype none

package timer_pkg;

	// Configuration value encodings
	localparam logic [2:0]  CFG_32_TIMER       = 3'h0;
	localparam logic [2:0]  CFG_32_RTC         = 3'h1;
	localparam logic [2:0]  CFG_16_SPLIT       = 3'h4;

	// Mode field encodings
	localparam logic [1:0]  MODE_ONE_SHOT      = 2'h1;
	localparam logic [1:0]  MODE_PERIODIC      = 2'h2;

	// Reset and start values
	localparam logic [15:0] COUNT_RESET        = 16'hFFFF;
	localparam logic [15:0] LOAD_RESET         = 16'hFFFF;
	localparam logic [7:0]  PRESCALE_RESET     = 8'h00;
	localparam logic [31:0] MATCH_RESET        = 32'hFFFFFFFF;
	localparam logic [31:0] RTC_START          = 32'h00000001;
	localparam logic [31:0] RTC_ROLLOVER       = 32'h00000000;

	// Real-time-clock divider: slow input rate over count rate
	localparam int unsigned SLOW_CLOCK_HZ      = 32768;
	localparam int unsigned RTC_TICK_HZ        = 1;
	localparam int unsigned RTC_DIVIDE_DEFAULT = SLOW_CLOCK_HZ / RTC_TICK_HZ;
	localparam int unsigned RTC_DIV_WIDTH      = 16;

	typedef struct packed {
		logic rtc_enable;
		logic b_debug_stall;
		logic b_enable;
		logic a_debug_stall;
		logic a_enable;
	} control_s;

	typedef struct packed {
		logic rtc_match;
		logic b_timeout;
		logic a_timeout;
	} status_s;

	localparam control_s CONTROL_RESET = '{default: 1'b0};
	localparam status_s  STATUS_RESET  = '{default: 1'b0};

endpackage : timer_pkg

`default_nettype wire

// ### design/slow_input_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes the input is asynchronous to i_clock and much slower than it.
`default_nettype none

module slow_input_sync (
	input  wire logic i_clock,
	input  wire logic i_reset,
	input  wire logic i_async,
	output var  logic o_level,
	output var  logic o_rise
);

	logic stage1_q;
	logic stage2_q;
	logic stage3_q;
	logic level_q;
	logic rise_q;

	wire agree = (stage2_q == stage3_q);

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			stage1_q <= 1'b0;
			stage2_q <= 1'b0;
			stage3_q <= 1'b0;
			level_q  <= 1'b0;
			rise_q   <= 1'b0;
		end else begin
			stage1_q <= i_async;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
			if (agree) begin
				level_q <= stage2_q;
			end
			rise_q   <= agree & stage2_q & ~level_q;
		end
	end

	assign o_level = level_q;
	assign o_rise  = rise_q;

endmodule // slow_input_sync

`default_nettype wire

// ### design/general_purpose_timer.sv
// General-purpose timer: two 16-bit counters used as one 32-bit timer,
// a 32-bit real-time clock, or two split 16-bit timers with prescalers.
// Assumes software keeps a timer disabled while reconfiguring it, and that
// every *_write input is a one-cycle strobe on i_clock.
//
// Functional notes
// [R1] Reset: inactive, counters and loads all ones
// [R2] Reset: both prescale values zero
// [R3] Config 0 timer mode, 1 RTC mode
// [R4] Config 4 splits into two 16-bit timers
// [R5] 32-bit load write fills both halves
// [R6] 32-bit count read is B:A
// [R7] 32-bit mode uses timer A mode only
// [R8] Count down, reload after zero, one-shot stops
// [R9] 32-bit zero sets sticky A time-out flag
// [R10] Load write while running takes effect next cycle
// [R11] Debug stall freezes count while halted
// [R12] RTC counts up from one on entry
// [R13] Slow input divided to one-second tick
// [R14] RTC match rolls count over to zero
// [R15] RTC match sets flag, clear drops it
// [R16] RTC enable overrides debug stall
// [R17] Split timers: 16-bit down with prescaler
// [R18] Split zero reloads count and prescale
// [R19] Split zero sets sticky time-out flag
// [R20] Clocks per count equal prescale plus one
// [R21] Software disables before changes, clears by ones
// [R22] Masked equals raw AND mask; interrupt ORs
`default_nettype none

module general_purpose_timer
	import timer_pkg::*;
#(
	parameter int unsigned RTC_DIVIDE = RTC_DIVIDE_DEFAULT
) (
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	input  wire logic [2:0]  i_timer_configuration,
	input  wire logic [1:0]  i_timer_a_mode_field,
	input  wire logic [1:0]  i_timer_b_mode_field,
	input  wire logic        i_control_write,
	input  wire control_s    i_timer_control,
	input  wire logic        i_load_a_write,
	input  wire logic [31:0] i_timer_a_interval_load,
	input  wire logic        i_load_b_write,
	input  wire logic [15:0] i_timer_b_interval_load,
	input  wire logic        i_prescale_a_write,
	input  wire logic [7:0]  i_timer_a_prescale,
	input  wire logic        i_prescale_b_write,
	input  wire logic [7:0]  i_timer_b_prescale,
	input  wire logic        i_match_write,
	input  wire logic [31:0] i_timer_a_match_value,
	input  wire status_s     i_interrupt_mask,
	input  wire logic        i_clear_write,
	input  wire status_s     i_interrupt_clear,
	input  wire logic        i_cpu_halted,
	input  wire logic        i_slow_clock_input,
	output var  control_s    o_timer_control,
	output var  logic [31:0] o_timer_a_count_value,
	output var  logic [15:0] o_timer_b_count_value,
	output var  status_s     o_raw_status,
	output var  status_s     o_masked_status,
	output var  logic        o_interrupt
);

	localparam logic [RTC_DIV_WIDTH-1:0] DIV_LAST = RTC_DIV_WIDTH'(RTC_DIVIDE - 1);

	// Index 0 is timer A, index 1 is timer B
	logic [1:0][15:0]         count_q;
	logic [1:0][15:0]         count_d;
	logic [1:0][15:0]         load_q;
	logic [1:0][15:0]         load_d;
	logic [1:0][7:0]          prescale_q;
	logic [1:0][7:0]          pre_count_q;
	logic [1:0][7:0]          pre_count_d;
	logic [31:0]              match_q;
	logic [2:0]               cfg_prev_q;
	logic [RTC_DIV_WIDTH-1:0] rtc_div_q;
	logic [RTC_DIV_WIDTH-1:0] rtc_div_d;
	control_s                 control_q;
	control_s                 control_d;
	status_s                  raw_q;
	status_s                  raw_d;
	status_s                  masked_q;
	status_s                  events;
	logic                     interrupt_q;
	logic [31:0]              count_read_q;
	logic [1:0]               hw_disable;
	logic                     slow_rise;

	slow_input_sync u_slow_sync (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.i_async (i_slow_clock_input),
		.o_level (),
		.o_rise  (slow_rise)
	);

	// Mode decode
	wire mode_32_timer = (i_timer_configuration == CFG_32_TIMER);        // [R3]
	wire mode_32_rtc   = (i_timer_configuration == CFG_32_RTC);          // [R3]
	wire mode_split    = (i_timer_configuration == CFG_16_SPLIT);        // [R4]
	wire mode_32       = mode_32_timer | mode_32_rtc;
	wire rtc_entry     = mode_32_rtc & (cfg_prev_q != CFG_32_RTC);       // [R12]

	wire [31:0] count32 = {count_q[1], count_q[0]};
	wire [31:0] load32  = {load_q[1], load_q[0]};
	wire [1:0]  modes[2];
	assign modes[0] = i_timer_a_mode_field;
	assign modes[1] = i_timer_b_mode_field;

	// Debug freeze per use; the RTC keeps time through a halt when enabled
	wire freeze_a   = control_q.a_debug_stall & i_cpu_halted;            // [R11]
	wire freeze_b   = control_q.b_debug_stall & i_cpu_halted;            // [R11]
	wire freeze_rtc = (freeze_a | freeze_b) & ~control_q.rtc_enable;     // [R16]

	wire run32     = mode_32_timer & control_q.a_enable & ~freeze_a;
	wire run_rtc   = mode_32_rtc & control_q.a_enable & ~freeze_rtc;
	wire [1:0] run16 = {mode_split & control_q.b_enable & ~freeze_b,
	                    mode_split & control_q.a_enable & ~freeze_a};

	// One-second tick; divider only advances in RTC mode so it starts aligned
	wire rtc_div_wrap = slow_rise & (rtc_div_q == DIV_LAST);
	wire sec_tick     = mode_32_rtc & rtc_div_wrap;                      // [R13]

	always_comb begin
		rtc_div_d = rtc_div_q;
		if (!mode_32_rtc) begin
			rtc_div_d = '0;
		end else if (rtc_div_wrap) begin
			rtc_div_d = '0;                                              // [R13]
		end else if (slow_rise) begin
			rtc_div_d = rtc_div_q + RTC_DIV_WIDTH'(1);
		end
	end

	// Counter next state
	always_comb begin
		count_d     = count_q;
		pre_count_d = pre_count_q;
		events      = STATUS_RESET;
		hw_disable  = 2'b00;
		if (run32) begin
			if (count32 == 32'h00000000) begin
				{count_d[1], count_d[0]} = load32;                       // [R8]
				events.a_timeout = 1'b1;                                 // [R9]
				if (modes[0] == MODE_ONE_SHOT) begin                     // [R7]
					hw_disable[0] = 1'b1;                                // [R8]
				end
			end else begin
				{count_d[1], count_d[0]} = count32 - 32'h00000001;       // [R8]
			end
		end
		if (rtc_entry) begin
			{count_d[1], count_d[0]} = RTC_START;                        // [R12]
		end else if (run_rtc && sec_tick) begin
			if (count32 == match_q) begin
				{count_d[1], count_d[0]} = RTC_ROLLOVER;                 // [R14]
				events.rtc_match = 1'b1;                                 // [R15]
			end else begin
				{count_d[1], count_d[0]} = count32 + 32'h00000001;       // [R12]
			end
		end
		for (int n = 0; n < 2; n++) begin
			if (run16[n]) begin
				if (pre_count_q[n] != 8'h00) begin
					pre_count_d[n] = pre_count_q[n] - 8'h01;             // [R20]
				end else begin
					pre_count_d[n] = prescale_q[n];                      // [R20]
					if (count_q[n] == 16'h0000) begin
						count_d[n] = load_q[n];                          // [R18]
						if (n == 0) begin
							events.a_timeout = 1'b1;                     // [R19]
						end else begin
							events.b_timeout = 1'b1;                     // [R19]
						end
						if (modes[n] == MODE_ONE_SHOT) begin             // [R17]
							hw_disable[n] = 1'b1;                        // [R18]
						end
					end else begin
						count_d[n] = count_q[n] - 16'h0001;              // [R17]
					end
				end
			end
		end
		// Outside RTC mode a load write reaches the counter on the next edge, running or not
		if (!mode_32_rtc) begin
			if (i_load_a_write && mode_32) begin
				{count_d[1], count_d[0]} = i_timer_a_interval_load;      // [R10]
			end else begin
				if (i_load_a_write) begin
					count_d[0] = i_timer_a_interval_load[15:0];          // [R10]
				end
				if (i_load_b_write) begin
					count_d[1] = i_timer_b_interval_load;                // [R10]
				end
			end
		end
	end

	// Load registers
	always_comb begin
		load_d = load_q;
		if (i_load_a_write && mode_32) begin
			load_d[0] = i_timer_a_interval_load[15:0];                   // [R5]
			load_d[1] = i_timer_a_interval_load[31:16];                  // [R5]
		end else begin
			if (i_load_a_write) begin
				load_d[0] = i_timer_a_interval_load[15:0];
			end
			if (i_load_b_write) begin
				load_d[1] = i_timer_b_interval_load;
			end
		end
	end

	// Enables: a software write in the same cycle beats the one-shot stop
	always_comb begin
		control_d = control_q;
		if (hw_disable[0]) begin
			control_d.a_enable = 1'b0;                                   // [R8]
		end
		if (hw_disable[1]) begin
			control_d.b_enable = 1'b0;                                   // [R18]
		end
		if (i_control_write) begin
			control_d = i_timer_control;
		end
	end

	// Sticky flags: a new event wins over a clear in the same cycle
	wire status_s clear_bits = i_clear_write ? i_interrupt_clear : STATUS_RESET; // [R21]
	assign raw_d = (raw_q & ~clear_bits) | events;                       // [R9] [R15] [R19]

	wire status_s masked_d  = raw_d & i_interrupt_mask;                 // [R22]
	wire [31:0] count_read_d = mode_32 ? {count_d[1], count_d[0]}       // [R6]
	                                   : {16'h0000, count_d[0]};

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			count_q      <= {COUNT_RESET, COUNT_RESET};                  // [R1]
			load_q       <= {LOAD_RESET, LOAD_RESET};                    // [R1]
			prescale_q   <= {PRESCALE_RESET, PRESCALE_RESET};            // [R2]
			pre_count_q  <= {PRESCALE_RESET, PRESCALE_RESET};            // [R2]
			match_q      <= MATCH_RESET;
			cfg_prev_q   <= CFG_32_TIMER;
			rtc_div_q    <= '0;
			control_q    <= CONTROL_RESET;                               // [R1]
			raw_q        <= STATUS_RESET;
			masked_q     <= STATUS_RESET;
			interrupt_q  <= 1'b0;
			count_read_q <= {COUNT_RESET, COUNT_RESET};
		end else begin
			count_q      <= count_d;
			load_q       <= load_d;
			pre_count_q  <= pre_count_d;
			cfg_prev_q   <= i_timer_configuration;
			rtc_div_q    <= rtc_div_d;
			control_q    <= control_d;
			raw_q        <= raw_d;
			masked_q     <= masked_d;                                    // [R22]
			interrupt_q  <= |masked_d;                                   // [R22]
			count_read_q <= count_read_d;
			if (i_prescale_a_write) begin
				prescale_q[0] <= i_timer_a_prescale;
			end
			if (i_prescale_b_write) begin
				prescale_q[1] <= i_timer_b_prescale;
			end
			if (i_match_write) begin
				match_q <= i_timer_a_match_value;
			end
		end
	end

	assign o_timer_control       = control_q;
	assign o_timer_a_count_value = count_read_q;
	assign o_timer_b_count_value = count_q[1];
	assign o_raw_status          = raw_q;
	assign o_masked_status       = masked_q;
	assign o_interrupt           = interrupt_q;

endmodule // general_purpose_timer

`default_nettype wire

// ### bench/general_purpose_timer_chk.sv
// Port-level concurrent checks for the general-purpose timer.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none

module general_purpose_timer_chk
	import timer_pkg::*;
#(
	parameter int unsigned RTC_DIVIDE = RTC_DIVIDE_DEFAULT
) (
	input wire logic        i_clock,
	input wire logic        i_reset,
	input wire logic [2:0]  i_timer_configuration,
	input wire logic [1:0]  i_timer_a_mode_field,
	input wire logic        i_control_write,
	input wire logic        i_load_a_write,
	input wire logic        i_load_b_write,
	input wire logic [31:0] i_timer_a_interval_load,
	input wire status_s     i_interrupt_mask,
	input wire logic        i_clear_write,
	input wire status_s     i_interrupt_clear,
	input wire logic        i_cpu_halted,
	input wire control_s    o_timer_control,
	input wire logic [31:0] o_timer_a_count_value,
	input wire logic [15:0] o_timer_b_count_value,
	input wire status_s     o_raw_status,
	input wire status_s     o_masked_status,
	input wire logic        o_interrupt
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);

	// Writes in the same cycle override counting, so they are kept out
	logic down_ok;
	logic go_32;
	assign down_ok = i_timer_configuration == CFG_32_TIMER && o_timer_control.a_enable
		&& !i_control_write && !i_load_a_write && !i_load_b_write;
	assign go_32 = down_ok && !(o_timer_control.a_debug_stall && i_cpu_halted);

	property p_reset;
		$past(i_reset) |-> o_timer_a_count_value[15:0] == 16'hFFFF
			&& o_timer_b_count_value == 16'hFFFF && o_raw_status == 3'h0
			&& o_timer_control == 5'h00;
	endproperty
	property p_load;
		i_load_a_write && i_timer_configuration == CFG_32_TIMER |=>
			o_timer_a_count_value == $past(i_timer_a_interval_load)
			&& o_timer_b_count_value == $past(i_timer_a_interval_load[31:16]);
	endproperty
	property p_split_load;
		i_load_a_write && i_timer_configuration == CFG_16_SPLIT |=>
			o_timer_a_count_value == {16'h0000, $past(i_timer_a_interval_load[15:0])};
	endproperty
	property p_count_down;
		go_32 && o_timer_a_count_value != 32'h0 |=>
			o_timer_a_count_value == $past(o_timer_a_count_value) - 32'h1;
	endproperty
	property p_stall;
		down_ok && o_timer_control.a_debug_stall && i_cpu_halted |=> $stable(o_timer_a_count_value);
	endproperty
	property p_expire;
		go_32 && i_timer_a_mode_field == MODE_ONE_SHOT && o_timer_a_count_value == 32'h0 |=>
			!o_timer_control.a_enable && o_raw_status.a_timeout;
	endproperty
	property p_sticky;
		o_raw_status.a_timeout && !(i_clear_write && i_interrupt_clear.a_timeout) |=>
			o_raw_status.a_timeout;
	endproperty
	property p_clear;
		i_clear_write && i_interrupt_clear.rtc_match
			&& i_timer_configuration != CFG_32_RTC |=> !o_raw_status.rtc_match;
	endproperty
	property p_masked;
		o_masked_status == (o_raw_status & $past(i_interrupt_mask))
			&& o_interrupt == |o_masked_status;
	endproperty

	a_reset: assert property (p_reset) else $error("reset values wrong");
	a_load: assert property (p_load) else $error("32-bit load split wrong");
	a_split_load: assert property (p_split_load) else $error("split load wrong");
	a_count_down: assert property (p_count_down) else $error("count step wrong");
	a_stall: assert property (p_stall) else $error("count moved while stalled");
	a_expire: assert property (p_expire) else $error("one-shot expiry wrong");
	a_sticky: assert property (p_sticky) else $error("time-out flag dropped");
	a_clear: assert property (p_clear) else $error("match flag not cleared");
	a_masked: assert property (p_masked) else $error("masked or interrupt wrong");

	c_zero: cover property (go_32 && o_timer_a_count_value == 32'h0);
	c_rtc: cover property ($rose(o_raw_status.rtc_match));
	c_b_out: cover property ($rose(o_raw_status.b_timeout));
endmodule // general_purpose_timer_chk

bind general_purpose_timer general_purpose_timer_chk #(.RTC_DIVIDE(RTC_DIVIDE)) u_chk (.*);

`default_nettype wire

// ### bench/general_purpose_timer_bench.sv
// Self-checking bench for the general-purpose timer.
// Assumes the design samples all inputs on the rising edge of i_clock.
`default_nettype none

module general_purpose_timer_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import timer_pkg::*;

	localparam int unsigned DIV = 4;
	logic        i_clock = 0, i_reset = 1, i_control_write = 0, i_load_a_write = 0;
	logic        i_load_b_write = 0, i_prescale_a_write = 0, i_prescale_b_write = 0;
	logic        i_match_write = 0, i_clear_write = 0, i_cpu_halted = 0, i_slow_clock_input = 0;
	logic [2:0]  i_timer_configuration = 0;
	logic [1:0]  i_timer_a_mode_field = 0, i_timer_b_mode_field = 0;
	control_s    i_timer_control = 0, o_timer_control;
	logic [31:0] i_timer_a_interval_load = 0, i_timer_a_match_value = 0, o_timer_a_count_value;
	logic [15:0] i_timer_b_interval_load = 0, o_timer_b_count_value;
	logic [7:0]  i_timer_a_prescale = 0, i_timer_b_prescale = 0;
	status_s     i_interrupt_mask = 0, i_interrupt_clear = 0, o_raw_status, o_masked_status;
	logic        o_interrupt;
	int          error_cnt = 0, comparisons = 0, n, p;
	logic [63:0] q[$], sq[$];
	bit          slow_run = 0;

	general_purpose_timer #(.RTC_DIVIDE(DIV)) u_general_purpose_timer (.*);

	initial forever #12.5 i_clock = !i_clock;
	// Slow pin idles between RTC runs; its phase is unrelated to i_clock
	always #212 if (slow_run) i_slow_clock_input = !i_slow_clock_input;

	task automatic cyc(input int k);
		repeat (k) @(posedge i_clock);
		#1;
	endtask
	task automatic wr(ref logic s);
		s = 1;
		cyc(1);
		s = 0;
	endtask
	function automatic logic [63:0] obs();
		return {4'h0, o_timer_control, o_raw_status, o_masked_status, o_interrupt,
			o_timer_b_count_value, o_timer_a_count_value};
	endfunction
	function automatic logic [63:0] ex(logic [4:0] c, logic [2:0] r, logic [15:0] b,
		logic [31:0] a);
		return {4'h0, c, r, r & i_interrupt_mask, |(r & i_interrupt_mask), b, a};
	endfunction
	// Seen values are queued too, so two notes in one time step stay paired
	task automatic note(input logic [63:0] e, s);
		q.push_back(e);
		sq.push_back(s);
	endtask
	task automatic wait_raw(input int b, lim, output int k);
		k = 0;
		while (o_raw_status[b] !== 1'b1 && k < lim) begin
			cyc(1);
			k++;
		end
		if (k == lim) error_cnt++;
	endtask
	task automatic check(input logic [63:0] s, e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial forever begin
		wait (sq.size() != 0);
		check(sq.pop_front(), q.pop_front());
	end

	initial begin
		repeat (5000) @(posedge i_clock);
		error_cnt++;
		summarize;
	end

	initial begin
		void'($urandom(48969));
		cyc(2);
		i_reset = 0;
		note(ex(5'h00, 3'h0, 16'hFFFF, 32'hFFFFFFFF), obs());
		$display("test reset done");

		i_interrupt_mask = 3'h7;
		i_timer_a_mode_field = MODE_ONE_SHOT;
		i_timer_b_mode_field = MODE_PERIODIC;
		i_timer_a_interval_load = 32'h00010000;
		wr(i_load_a_write);
		note(ex(5'h00, 3'h0, 16'h0001, 32'h00010000), obs());
		i_timer_control = 5'h01;
		wr(i_control_write);
		cyc(1);
		note(ex(5'h01, 3'h0, 16'h0000, 32'h0000FFFF), obs());
		i_timer_a_interval_load = 32'h00000003;
		wr(i_load_a_write);
		note(ex(5'h01, 3'h0, 16'h0000, 32'h00000003), obs());
		cyc(4);
		note(ex(5'h00, 3'h1, 16'h0000, 32'h00000003), obs());
		cyc(5);
		note(ex(5'h00, 3'h1, 16'h0000, 32'h00000003), obs());
		i_interrupt_clear = 3'h1;
		wr(i_clear_write);
		note(ex(5'h00, 3'h0, 16'h0000, 32'h00000003), obs());
		$display("test one-shot done");

		// Stalled start, then periodic reload with the time-out masked off
		i_timer_a_mode_field = MODE_PERIODIC;
		i_interrupt_mask = 3'h2;
		i_timer_a_interval_load = 32'h00000002;
		wr(i_load_a_write);
		i_timer_control = 5'h03;
		i_cpu_halted = 1;
		wr(i_control_write);
		cyc(4);
		note(ex(5'h03, 3'h0, 16'h0000, 32'h00000002), obs());
		i_cpu_halted = 0;
		cyc(3);
		note(ex(5'h03, 3'h1, 16'h0000, 32'h00000002), obs());
		i_timer_control = 5'h00;
		wr(i_control_write);
		wr(i_clear_write);
		$display("test periodic done");

		i_timer_configuration = CFG_16_SPLIT;
		p = $urandom % 4;
		i_timer_a_prescale = p[7:0];
		wr(i_prescale_a_write);
		i_timer_a_interval_load = 32'h00050003;
		wr(i_load_a_write);
		note(ex(5'h00, 3'h0, 16'h0000, 32'h00000003), obs());
		i_timer_b_interval_load = 16'h0001;
		wr(i_load_b_write);
		i_timer_b_mode_field = MODE_ONE_SHOT;
		i_timer_control = 5'h05;
		wr(i_control_write);
		wait_raw(0, 200, n);
		wr(i_clear_write);
		wait_raw(0, 200, n);
		note(4 * (p + 1) - 1, n);
		note(64'h1, {o_timer_control.b_enable, o_raw_status.b_timeout});
		i_timer_control = 5'h00;
		wr(i_control_write);
		i_interrupt_clear = 3'h7;
		wr(i_clear_write);
		$display("test split done");

		i_timer_configuration = CFG_32_RTC;
		cyc(1);
		note(ex(5'h00, 3'h0, 16'h0000, 32'h00000001), obs());
		i_timer_a_match_value = 32'h00000002;
		wr(i_match_write);
		i_interrupt_mask = 3'h4;
		i_timer_control = 5'h13;
		i_cpu_halted = 1;
		wr(i_control_write);
		slow_run = 1;
		wait_raw(2, 900, n);
		note(ex(5'h13, 3'h4, 16'h0000, 32'h00000000), obs());
		i_interrupt_clear = 3'h4;
		wr(i_clear_write);
		note(ex(5'h13, 3'h0, 16'h0000, 32'h00000000), obs());
		slow_run = 0;
		i_cpu_halted = 0;
		$display("test rtc done");
		cyc(1);
		summarize;
	end
endmodule // general_purpose_timer_bench

`default_nettype wire
